/* File: verilog/pump_relay_pkg.sv */
package pump_relay_pkg;

    // ******************************************************************
    // Register offsets (byte addresses on the APB bus)
    // ******************************************************************
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] LEVEL_OFFSET = 12'h004;
    localparam logic [11:0] RATE_OFFSET = 12'h008;
    localparam logic [11:0] FILL_RATE_OFFSET = 12'h00C;
    localparam logic [11:0] EMPTY_RATE_OFFSET = 12'h010;
    localparam logic [11:0] STATUS_OFFSET = 12'h014;
    localparam logic [11:0] FUNC_BASE = 12'h040;
    localparam logic [11:0] ON_SP_BASE = 12'h080;
    localparam logic [11:0] OFF_SP_BASE = 12'h0C0;
    localparam logic [11:0] RATIO_BASE = 12'h100;
    localparam logic [11:0] RUNTIME_BASE = 12'h140;
    localparam logic [11:0] BANK_MASK = 12'hFC0;

    // ******************************************************************
    // Control register fields
    // ******************************************************************
    localparam int CTRL_LOGIC_LSB = 0;
    localparam int CTRL_RATE_EN_BIT = 4;
    localparam int CTRL_PUMP_UP_BIT = 5;
    localparam logic [3:0] LOGIC_RESET = 4'h2;
    localparam logic [3:0] LOGIC_PUMP = 4'h2;

    // ******************************************************************
    // Relay control function codes
    // ******************************************************************
    localparam logic [7:0] FUNC_RESET = 8'h00;
    localparam logic [7:0] FUNC_FIXED_ASSIST = 8'h32;
    localparam logic [7:0] FUNC_FIXED_BACKUP = 8'h33;
    localparam logic [7:0] FUNC_ALT_ASSIST = 8'h34;
    localparam logic [7:0] FUNC_ALT_BACKUP = 8'h35;
    localparam logic [7:0] FUNC_RATIO_ASSIST = 8'h36;
    localparam logic [7:0] FUNC_RATIO_BACKUP = 8'h37;

    // ******************************************************************
    // Status register fields
    // ******************************************************************
    localparam int STAT_STAGE_LSB = 0;
    localparam int STAT_LEAD_LSB = 4;
    localparam int STAT_SIZE_LSB = 8;
    localparam int STAT_RELAY_LSB = 16;

    // ******************************************************************
    // Widths and timing
    // ******************************************************************
    localparam int IDX_W = 4;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETTLE_TIME_MS = 5;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RUNTIME_TICK_MS = 1000;
    localparam int RUNTIME_TICK_CYCLES = (RUNTIME_TICK_MS * 1000000) / CLK_PERIOD_NS;

    // Sequencer states
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_SETTLE = 2'b10
    } seq_state_type;

endpackage

/* File: verilog/pump_relay_sequencer.sv */
// Functional notes
// - Relays sharing one function code form group.
// - Rate mode adds pumps until rate met.
// - Code 50 binds relay n to setpoint n.
// - Logic 2: close at ON, open at OFF.
// - Fixed assist: ON n closes relays 1..n.
// - Fixed backup: ON n closes only relay n.
// - Alternate assist rotates lead, pumps run together.
// - Alternate duty maps setpoints through rotating lead.
// - Alternate backup: one relay per setpoint, rotated.
// - Backup variants only on six-relay build.
// - Fixed duty always starts same pumps, same order.
// - Service ratio picks lead by run-time ratios.
module pump_relay_sequencer #(
    parameter int NUM_RELAYS = 6,
    parameter bit SIX_RELAY_MODEL = 1'b1,
    parameter int SETTLE_CYCLES = pump_relay_pkg::SETTLE_CYCLES,
    parameter int RUNTIME_TICK_CYCLES = pump_relay_pkg::RUNTIME_TICK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pump relay contacts, high closes the contact
    output logic [NUM_RELAYS-1:0] pump_relay
);

    // ******************************************************************
    // State of the block
    // ******************************************************************
    typedef struct packed {
        logic [NUM_RELAYS-1:0][7:0] relay_control_function; // Per relay code
        logic [NUM_RELAYS-1:0][15:0] on_sp;                 // ON setpoints 1..N
        logic [NUM_RELAYS-1:0][15:0] off_sp;                // OFF setpoints 1..N
        logic [NUM_RELAYS-1:0][7:0] ratio;                  // Service ratios
        logic [NUM_RELAYS-1:0][15:0] runtime;               // Run time, ticks
        logic [3:0] relay_output_logic;                     // Contact logic
        logic rate_pumping_enable;                          // Pump by rate
        logic pump_up;                                      // Filling duty
        logic [15:0] level;                                 // Measured level
        logic [15:0] rate;                                  // Signed level rate
        logic [15:0] filling_rate_setpoint;
        logic [15:0] emptying_rate_setpoint;
        pump_relay_pkg::seq_state_type seq;                 // Sequencer state
        logic [pump_relay_pkg::IDX_W-1:0] stage;            // Pumps called
        logic [pump_relay_pkg::IDX_W-1:0] lead;             // Lead relay
        logic [31:0] settle_cnt;                            // Rate settle timer
        logic [31:0] tick_cnt;                              // Run-time prescaler
        logic [NUM_RELAYS-1:0] relay;                       // Registered contacts
        logic [31:0] rd_data;                               // Read data
        logic rd_err;                                       // Unmapped access
    } state_type;

    state_type s;
    state_type next_s;

    // Working signals of the combinational process
    logic [7:0] code;                                        // Group code
    logic group_ok;                                          // Code usable here
    logic [pump_relay_pkg::IDX_W-1:0] size;                  // Group members
    logic [pump_relay_pkg::IDX_W-1:0] top_on;                // Highest ON tripped
    logic [pump_relay_pkg::IDX_W-1:0] pos;                   // Rotated position
    logic [pump_relay_pkg::IDX_W-1:0] best;                  // Ratio choice
    logic [pump_relay_pkg::IDX_W-1:0] ridx;                  // Register index
    logic [11:0] bank;                                       // Register bank
    logic counting;                                          // Leading members
    logic rate_met;                                          // Rate reached
    logic tick;                                              // Run-time tick
    logic backup;                                            // One pump at a time
    logic rotating;                                          // Alternate duty
    logic by_ratio;                                          // Service ratio duty
    logic [23:0] lhs;
    logic [23:0] rhs;
    logic [15:0] neg_rate;

    assign pready = 1'b1;
    assign pslverr = psel && penable && s.rd_err;
    assign prdata = s.rd_data;
    assign pump_relay = s.relay;

    // ******************************************************************
    // Next-state logic
    // ******************************************************************
    always_comb
    begin
        next_s = s;
        code = s.relay_control_function[0];
        size = '0;
        top_on = '0;
        pos = '0;
        best = s.lead;
        counting = 1'b1;
        lhs = '0;
        rhs = '0;
        ridx = paddr[5:2];
        bank = paddr & pump_relay_pkg::BANK_MASK;
        neg_rate = 16'h0000 - s.rate;

        // Group is the run of relays from relay 1 sharing relay 1's code
        for (int r = 0; r < NUM_RELAYS; r++)
        begin
            if (counting && s.relay_control_function[r] == code)
            begin
                size = size + 1'b1;
            end
            else
            begin
                counting = 1'b0;
            end
        end

        // Backup codes exist only on the six-relay build
        backup = (code == pump_relay_pkg::FUNC_FIXED_BACKUP)
            || (code == pump_relay_pkg::FUNC_ALT_BACKUP)
            || (code == pump_relay_pkg::FUNC_RATIO_BACKUP);
        rotating = (code == pump_relay_pkg::FUNC_ALT_ASSIST)
            || (code == pump_relay_pkg::FUNC_ALT_BACKUP);
        by_ratio = (code == pump_relay_pkg::FUNC_RATIO_ASSIST)
            || (code == pump_relay_pkg::FUNC_RATIO_BACKUP);
        group_ok = (code >= pump_relay_pkg::FUNC_FIXED_ASSIST)
            && (code <= pump_relay_pkg::FUNC_RATIO_BACKUP)
            && (SIX_RELAY_MODEL || !backup)
            && (s.relay_output_logic == pump_relay_pkg::LOGIC_PUMP);

        // Highest ON setpoint that the level has reached
        for (int n = 0; n < NUM_RELAYS; n++)
        begin
            if (n < int'(size))
            begin
                if (s.pump_up ? (s.level <= s.on_sp[n]) : (s.level >= s.on_sp[n]))
                begin
                    top_on = pump_relay_pkg::IDX_W'(n + 1);
                end
            end
        end

        // Rate reached: emptying rate when pumping down, filling when up
        rate_met = s.pump_up
            ? (!s.rate[15] && s.rate >= s.filling_rate_setpoint)
            : (s.rate[15] && neg_rate >= s.emptying_rate_setpoint);

        // Service ratio: member with least run time per unit of ratio
        for (int i = 0; i < NUM_RELAYS; i++)
        begin
            if (i < int'(size) && s.ratio[i] != 8'h00)
            begin
                lhs = 24'(s.runtime[i]) * 24'(s.ratio[best]);
                rhs = 24'(s.runtime[best]) * 24'(s.ratio[i]);
                if (s.ratio[best] == 8'h00 || lhs < rhs)
                begin
                    best = pump_relay_pkg::IDX_W'(i);
                end
            end
        end

        // Sequencer
        case (s.seq)
            pump_relay_pkg::ST_IDLE:
            begin
                // First pump starts on ON 1 under rate mode, else the highest ON
                if (group_ok && top_on != '0)
                begin
                    next_s.stage = s.rate_pumping_enable ? 4'h1 : top_on;
                    next_s.seq = pump_relay_pkg::ST_RUN;
                    next_s.settle_cnt = '0;
                end
            end
            pump_relay_pkg::ST_RUN, pump_relay_pkg::ST_SETTLE:
            begin
                if (s.rate_pumping_enable)
                begin
                    // Add one pump at a time after the rate has had time to settle
                    if (s.stage < size && !rate_met)
                    begin
                        next_s.seq = pump_relay_pkg::ST_SETTLE;
                        next_s.settle_cnt = s.settle_cnt + 1;
                        if (s.settle_cnt >= 32'(SETTLE_CYCLES - 1))
                        begin
                            next_s.stage = s.stage + 1'b1;
                            next_s.settle_cnt = '0;
                        end
                    end
                    else
                    begin
                        next_s.seq = pump_relay_pkg::ST_RUN;
                        next_s.settle_cnt = '0;
                    end
                end
                else if (top_on > s.stage)
                begin
                    next_s.stage = top_on;
                end
                // OFF setpoint k drops demand to below k
                for (int k = NUM_RELAYS - 1; k >= 0; k--)
                begin
                    if (k < int'(s.stage) && k < int'(size))
                    begin
                        if (s.pump_up ? (s.level >= s.off_sp[k]) : (s.level <= s.off_sp[k]))
                        begin
                            next_s.stage = pump_relay_pkg::IDX_W'(k);
                        end
                    end
                end
                // Lost group ends the cycle at once
                if (!group_ok)
                begin
                    next_s.stage = '0;
                end
                if (next_s.stage == '0)
                begin
                    next_s.seq = pump_relay_pkg::ST_IDLE;
                    next_s.settle_cnt = '0;
                    // Level cycle done: alternate duty advances the lead, wrapping at group end; ratio duty takes best
                    if (rotating)
                    begin
                        next_s.lead = (s.lead + 1'b1 >= size) ? '0 : s.lead + 1'b1;
                    end
                    else if (by_ratio)
                    begin
                        next_s.lead = best;
                    end
                end
            end
            default:
            begin
                next_s.seq = pump_relay_pkg::ST_IDLE;
                next_s.stage = '0;
            end
        endcase

        // Fixed duty keeps relay 1 as lead, so order never changes
        if (!rotating && !by_ratio)
        begin
            next_s.lead = '0;
        end
        // A shrunken group must not leave the lead outside it
        if (next_s.lead >= size)
        begin
            next_s.lead = '0;
        end

        // Relay map: position counted from the lead, cyclic in the group
        for (int r = 0; r < NUM_RELAYS; r++)
        begin
            pos = (pump_relay_pkg::IDX_W'(r) >= s.lead)
                ? pump_relay_pkg::IDX_W'(r) - s.lead
                : pump_relay_pkg::IDX_W'(r) + size - s.lead;
            if (r >= int'(size) || !group_ok || s.stage == '0)
            begin
                next_s.relay[r] = 1'b0;
            end
            else if (backup)
            begin
                next_s.relay[r] = (pos == s.stage - 1'b1);
            end
            else
            begin
                next_s.relay[r] = (pos < s.stage);
            end
        end

        // Run-time accumulation for the service ratio choice
        tick = (s.tick_cnt >= 32'(RUNTIME_TICK_CYCLES - 1));
        next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1;
        for (int r = 0; r < NUM_RELAYS; r++)
        begin
            // Saturate rather than wrap, so an old pump never looks fresh
            if (tick && s.relay[r] && s.runtime[r] != 16'hFFFF)
            begin
                next_s.runtime[r] = s.runtime[r] + 1'b1;
            end
        end

        // ******************************************************************
        // APB register access
        // ******************************************************************
        // Read data is captured in the setup cycle and shown in the access cycle
        if (psel && !penable)
        begin
            next_s.rd_data = '0;
            next_s.rd_err = 1'b0;
            if (paddr[1:0] != 2'b00)
            begin
                next_s.rd_err = 1'b1;
            end
            else if (bank == 12'h000)
            begin
                case (paddr)
                    pump_relay_pkg::CTRL_OFFSET:
                    begin
                        next_s.rd_data[pump_relay_pkg::CTRL_LOGIC_LSB +: 4] = s.relay_output_logic;
                        next_s.rd_data[pump_relay_pkg::CTRL_RATE_EN_BIT] = s.rate_pumping_enable;
                        next_s.rd_data[pump_relay_pkg::CTRL_PUMP_UP_BIT] = s.pump_up;
                    end
                    pump_relay_pkg::LEVEL_OFFSET: next_s.rd_data[15:0] = s.level;
                    pump_relay_pkg::RATE_OFFSET: next_s.rd_data[15:0] = s.rate;
                    pump_relay_pkg::FILL_RATE_OFFSET:
                        next_s.rd_data[15:0] = s.filling_rate_setpoint;
                    pump_relay_pkg::EMPTY_RATE_OFFSET:
                        next_s.rd_data[15:0] = s.emptying_rate_setpoint;
                    pump_relay_pkg::STATUS_OFFSET:
                    begin
                        next_s.rd_data[pump_relay_pkg::STAT_STAGE_LSB +: 4] = s.stage;
                        next_s.rd_data[pump_relay_pkg::STAT_LEAD_LSB +: 4] = s.lead;
                        next_s.rd_data[pump_relay_pkg::STAT_SIZE_LSB +: 4] = size;
                        next_s.rd_data[pump_relay_pkg::STAT_RELAY_LSB +: NUM_RELAYS] = s.relay;
                    end
                    default: next_s.rd_err = 1'b1;
                endcase
            end
            else if (int'(ridx) >= NUM_RELAYS)
            begin
                next_s.rd_err = 1'b1;
            end
            else
            begin
                case (bank)
                    pump_relay_pkg::FUNC_BASE:
                        next_s.rd_data[7:0] = s.relay_control_function[ridx];
                    pump_relay_pkg::ON_SP_BASE: next_s.rd_data[15:0] = s.on_sp[ridx];
                    pump_relay_pkg::OFF_SP_BASE: next_s.rd_data[15:0] = s.off_sp[ridx];
                    pump_relay_pkg::RATIO_BASE: next_s.rd_data[7:0] = s.ratio[ridx];
                    pump_relay_pkg::RUNTIME_BASE: next_s.rd_data[15:0] = s.runtime[ridx];
                    default: next_s.rd_err = 1'b1;
                endcase
            end
        end

        // Writes take effect at the access edge; status is read only, a run time write clears it
        if (psel && penable && pwrite && !s.rd_err)
        begin
            case (bank)
                12'h000:
                begin
                    case (paddr)
                        pump_relay_pkg::CTRL_OFFSET:
                        begin
                            next_s.relay_output_logic =
                                pwdata[pump_relay_pkg::CTRL_LOGIC_LSB +: 4];
                            next_s.rate_pumping_enable = pwdata[pump_relay_pkg::CTRL_RATE_EN_BIT];
                            next_s.pump_up = pwdata[pump_relay_pkg::CTRL_PUMP_UP_BIT];
                        end
                        pump_relay_pkg::LEVEL_OFFSET: next_s.level = pwdata[15:0];
                        pump_relay_pkg::RATE_OFFSET: next_s.rate = pwdata[15:0];
                        pump_relay_pkg::FILL_RATE_OFFSET:
                            next_s.filling_rate_setpoint = pwdata[15:0];
                        pump_relay_pkg::EMPTY_RATE_OFFSET:
                            next_s.emptying_rate_setpoint = pwdata[15:0];
                        default:
                        begin
                        end
                    endcase
                end
                pump_relay_pkg::FUNC_BASE: next_s.relay_control_function[ridx] = pwdata[7:0];
                pump_relay_pkg::ON_SP_BASE: next_s.on_sp[ridx] = pwdata[15:0];
                pump_relay_pkg::OFF_SP_BASE: next_s.off_sp[ridx] = pwdata[15:0];
                pump_relay_pkg::RATIO_BASE: next_s.ratio[ridx] = pwdata[7:0];
                pump_relay_pkg::RUNTIME_BASE:
                begin
                    // Any write clears that pump's run time, e.g. after a swap
                    next_s.runtime[ridx] = 16'h0000;
                end
                default:
                begin
                end
            endcase
        end
    end

    // ******************************************************************
    // State register
    // ******************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.relay_output_logic <= pump_relay_pkg::LOGIC_RESET;
            s.seq <= pump_relay_pkg::ST_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

/* File: testbench/pump_relay_asserts.sv */
module pump_relay_asserts #(
    parameter int NUM_RELAYS = 6,
    parameter bit SIX_RELAY_MODEL = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Relays
    input wire logic [NUM_RELAYS-1:0] pump_relay
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Shadow of the settings that gate relays
    // ****************************************
    logic wr; // Accepted write at this edge
    logic [3:0] logic_sh; // Output logic setting
    logic rate_sh; // Rate mode enable
    logic [7:0] func0; // Function code of relay 1
    assign wr = psel && penable && pwrite && pready && !pslverr;
    // Track writes so the checks know the active strategy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            logic_sh <= 4'h2;
            rate_sh <= 1'b0;
            func0 <= 8'h00;
        end
        else if (wr && paddr == pump_relay_pkg::CTRL_OFFSET)
        begin
            logic_sh <= pwdata[3:0];
            rate_sh <= pwdata[4];
        end
        else if (wr && paddr == pump_relay_pkg::FUNC_BASE)
            func0 <= pwdata[7:0];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    fixed_backup_a: assert property (func0 == 8'h33 [*3] |-> $onehot0(pump_relay))
        else $error("fixed backup closed two relays");
    alt_backup_a: assert property (func0 == 8'h35 [*3] |-> $onehot0(pump_relay))
        else $error("alternate backup closed two relays");
    fixed_assist_a: assert property (func0 == 8'h32 [*3] |->
        (pump_relay & (pump_relay + 1'b1)) == '0) else $error("fixed assist not 1..n");
    logic_off_a: assert property (logic_sh != 4'h2 [*3] |-> pump_relay == '0)
        else $error("relay closed with other logic");
    logic_write_a: assert property (wr && paddr == 12'h000 && pwdata[3:0] != 4'h2
        |-> ##2 pump_relay == '0) else $error("relays not opened");
    no_spont_a: assert property (!rate_sh && $changed(pump_relay)
        |-> $past(wr, 2) || $past(wr, 3)) else $error("relay moved without a write");
    bad_code_a: assert property ((func0 < 8'h32 || func0 > 8'h37) [*3]
        |-> pump_relay == '0) else $error("relay closed without group");
    small_model_a: assert property (!SIX_RELAY_MODEL && func0 inside {8'h33, 8'h35, 8'h37}
        |-> ##2 pump_relay == '0) else $error("backup used on small model");
endmodule
bind pump_relay_sequencer pump_relay_asserts #(.NUM_RELAYS(NUM_RELAYS),
    .SIX_RELAY_MODEL(SIX_RELAY_MODEL)) chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .pump_relay(pump_relay));

/* File: testbench/pump_contactors.sv */
module pump_contactors #(
    parameter int NUM_RELAYS = 6
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Relay coils in, motor feedback out
    input wire logic [NUM_RELAYS-1:0] pump_relay,
    output logic [NUM_RELAYS-1:0] running
);
    timeunit 1ns;
    timeprecision 1ns;
    // Contactor pulls in one clock after its coil, so a glitch shows late
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            running <= '0;
        else
            running <= pump_relay;
    end
endmodule

/* File: testbench/tb_pump_relay_sequencer.sv */
module tb_pump_relay_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Signals
    // ****************************************
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata;
    logic pready, pslverr, rerr;
    logic [5:0] pump_relay, running, small_relay;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    int codes[4] = '{50, 51, 52, 53};
    always #25 pclk = ~pclk;
    // Short settle and tick counts keep the run brief
    pump_relay_sequencer #(.SETTLE_CYCLES(4), .RUNTIME_TICK_CYCLES(8)) pump_relay_sequencer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pump_relay(pump_relay));
    pump_contactors pump_contactors_i (.pclk(pclk), .presetn(presetn),
        .pump_relay(pump_relay), .running(running));
    // Small build
    pump_relay_sequencer #(.SIX_RELAY_MODEL(1'b0), .SETTLE_CYCLES(4), .RUNTIME_TICK_CYCLES(8))
        pump_relay_sequencer_small_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .pump_relay(small_relay));
    // ****************************************
    // Tasks
    // ****************************************
    task finish_test;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Relays settle two edges after the write, the contactors one more
    task lvl(input logic [31:0] l, input logic [5:0] e);
        apb(1, pump_relay_pkg::LEVEL_OFFSET, l);
        repeat (4) @(posedge pclk);
        chk(pump_relay, e);
        chk(running, e);
    endtask
    // Lead advances per cycle for alternate duty only; odd codes run one pump
    function automatic logic [5:0] expv(int code, int c, int st);
        logic [5:0] v;
        int lead;
        v = '0;
        lead = (code >= 52) ? c % 3 : 0;
        for (int p = 0; p < 3; p++)
            if (code[0] ? p == st - 1 : p < st)
                v[(lead + p) % 3] = 1'b1;
        return v;
    endfunction
    // Hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            n_errors++;
            finish_test;
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, pump_relay_pkg::CTRL_OFFSET, 0);
        chk(rdata, 32'h00000002);
        for (int i = 0; i < 3; i++)
        begin
            apb(1, pump_relay_pkg::ON_SP_BASE + 12'(4 * i), 100 * (i + 1));
            apb(1, pump_relay_pkg::OFF_SP_BASE + 12'(4 * i), 10 * (i + 1));
        end
        foreach (codes[k])
        begin
            for (int i = 0; i < 3; i++)
                apb(1, pump_relay_pkg::FUNC_BASE + 12'(4 * i), codes[k]);
            for (int c = 0; c < 3; c++)
            begin
                for (int s = 1; s <= 3; s++)
                begin
                    lvl(100 * s + 50, expv(codes[k], c, s));
                    chk(small_relay, codes[k][0] ? 6'h00 : expv(codes[k], c, s));
                end
                lvl(5, 6'h00);
            end
        end
        // Another output logic opens every contact
        lvl(350, expv(53, 0, 3));
        apb(1, pump_relay_pkg::CTRL_OFFSET, 3);
        repeat (4) @(posedge pclk);
        chk(pump_relay, 6'h00);
        apb(1, pump_relay_pkg::CTRL_OFFSET, 2);
        lvl(5, 6'h00);
        // Rate mode adds one pump per settle time
        for (int i = 0; i < 3; i++)
            apb(1, pump_relay_pkg::FUNC_BASE + 12'(4 * i), 50);
        apb(1, pump_relay_pkg::EMPTY_RATE_OFFSET, 16);
        apb(1, pump_relay_pkg::CTRL_OFFSET, 32'h12);
        lvl(150, 6'h01);
        repeat (2) @(posedge pclk);
        chk(pump_relay, 6'h03);
        repeat (6) @(posedge pclk);
        chk(pump_relay, 6'h07);
        lvl(5, 6'h00);
        apb(1, pump_relay_pkg::RATE_OFFSET, 32'hFFF0);
        lvl(150, 6'h01);
        repeat (8) @(posedge pclk);
        chk(pump_relay, 6'h01);
        // Unmapped place and a relay index past the last relay
        apb(0, 12'h200, 0);
        chk(rerr, 1'b1);
        apb(0, pump_relay_pkg::FUNC_BASE + 12'h018, 0);
        chk(rerr, 1'b1);
        chk(rdata, 0);
        finish_test;
    end
endmodule
